// ==== hw/dcfree_coder.sv ====
// Packet line coder, interrupt routing and packet option decoding
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/10ps
`include "dcfree_regs.svh"
module dcfree_coder #(
  parameter logic [8:0] WH_TAPS = `WH_TAPS,
  parameter logic [8:0] WH_SEED = `WH_SEED
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tx_bit,
  input wire logic tx_coded,
  input wire logic tx_bit_valid,
  output logic tx_bit_ready,
  output logic tx_chip,
  output logic tx_chip_valid,
  input wire logic rx_chip,
  input wire logic rx_coded,
  input wire logic rx_chip_valid,
  output logic rx_bit,
  output logic rx_bit_valid,
  input wire logic [6:0] fifo_count,
  input wire logic ev_payload_ready,
  input wire logic ev_write_byte,
  input wire logic ev_fifo_not_empty,
  input wire logic ev_sync,
  input wire logic ev_adrs_match,
  input wire logic ev_crc_ok,
  input wire logic ev_crc_fail,
  input wire logic ev_fifo_full,
  input wire logic ev_rssi,
  input wire logic ev_tx_done,
  output logic irq0,
  output logic irq1,
  output logic tx_start,
  output logic fifo_clear,
  output logic [1:0] preamble_bytes,
  output logic [1:0] sync_tol,
  output logic [7:0] len_limit,
  output logic len_exact,
  output logic [1:0] adrs_filt
);
  logic [7:0] ctrl_q, irqsel_q, thresh_q, paylen_q, pktcfg_q;
  logic [15:0] rate_q;
  logic [7:0] rdata_q;
  logic code_err_q;
  logic [15:0] div_q;
  logic chip_tick;
  logic wr_ctrl, wr_irqsel, wr_thresh, wr_paylen, wr_pktcfg;
  logic wr_rlo, wr_rhi, clr_err;
  logic [7:0] rd_mux, status;
  dcfree_pkg::chip_mode_t mode;
  logic pkt_mode, man_on, wh_on, is_rx, is_tx, is_stby;

  ////////////////////////////////////////////////////////////////////////
  // Register port
  assign wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);
  assign wr_irqsel = reg_wr && (reg_addr == `REG_IRQSEL);
  assign wr_thresh = reg_wr && (reg_addr == `REG_THRESH);
  assign wr_paylen = reg_wr && (reg_addr == `REG_PAYLEN);
  assign wr_pktcfg = reg_wr && (reg_addr == `REG_PKTCFG);
  assign wr_rlo = reg_wr && (reg_addr == `REG_RATE_LO);
  assign wr_rhi = reg_wr && (reg_addr == `REG_RATE_HI);
  assign clr_err = reg_wr && (reg_addr == `REG_STATUS) &&
                   reg_wdata[`ST_CODEERR];
  assign status = {4'h0, code_err_q, tx_start, irq1, irq0};
  assign rd_mux = (reg_addr == `REG_CTRL) ? ctrl_q :
                  (reg_addr == `REG_IRQSEL) ? irqsel_q :
                  (reg_addr == `REG_THRESH) ? thresh_q :
                  (reg_addr == `REG_PAYLEN) ? paylen_q :
                  (reg_addr == `REG_PKTCFG) ? pktcfg_q :
                  (reg_addr == `REG_RATE_LO) ? rate_q[7:0] :
                  (reg_addr == `REG_RATE_HI) ? rate_q[15:8] :
                  (reg_addr == `REG_STATUS) ? status : 8'h00;
  assign reg_rdata = rdata_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= `CTRL_RST;
      irqsel_q <= `IRQSEL_RST;
      thresh_q <= `THRESH_RST;
      paylen_q <= `PAYLEN_RST;
      pktcfg_q <= `PKTCFG_RST;
      rate_q <= `RATE_RST;
      rdata_q <= 8'h00;
    end
    else if (ce)
    begin
      if (wr_ctrl) ctrl_q <= reg_wdata;
      if (wr_irqsel) irqsel_q <= reg_wdata;
      if (wr_thresh) thresh_q <= reg_wdata;
      if (wr_paylen) paylen_q <= reg_wdata;
      if (wr_pktcfg) pktcfg_q <= reg_wdata;
      if (wr_rlo) rate_q[7:0] <= reg_wdata;
      if (wr_rhi) rate_q[15:8] <= reg_wdata;
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign mode = ctrl_q[`CTRL_MODE];
  assign pkt_mode = ctrl_q[`CTRL_PKT_BIT];
  assign man_on = ctrl_q[`CTRL_MAN] && pkt_mode;
  assign wh_on = ctrl_q[`CTRL_WH] && pkt_mode;
  assign is_rx = (mode == `MODE_RX);
  assign is_tx = (mode == `MODE_TX);
  assign is_stby = (mode == `MODE_STBY);

  // One divider for every chip of the frame
  assign chip_tick = (div_q == 16'h0000);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      div_q <= 16'h0000;
    else if (ce)
      div_q <= chip_tick ? rate_q : div_q - 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit coder
  dcfree_pkg::chip_phase_e tx_ph_q;
  logic tx_second_q, tx_chip_q, tx_cv_q, tx_in_pay_q;
  logic tx_acc, tx_wh, tx_wh_bit, tx_nrz, tx_seed;

  assign tx_bit_ready = chip_tick && (tx_ph_q == dcfree_pkg::PH_FIRST);
  assign tx_acc = tx_bit_ready && tx_bit_valid;
  assign tx_seed = tx_acc && tx_coded && !tx_in_pay_q;
  assign tx_wh = wh_on && tx_coded;
  assign tx_nrz = tx_bit ^ (tx_wh && tx_wh_bit);
  assign tx_chip = tx_chip_q;
  assign tx_chip_valid = tx_cv_q;

  whiten_lfsr #(.TAPS(WH_TAPS), .SEED(WH_SEED)) u_tx_lfsr (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .load(tx_seed),
    .step(tx_acc && tx_wh),
    .rnd(tx_wh_bit)
  );

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_ph_q <= dcfree_pkg::PH_FIRST;
      tx_second_q <= 1'b0;
      tx_chip_q <= 1'b0;
      tx_cv_q <= 1'b0;
      tx_in_pay_q <= 1'b0;
    end
    else if (ce)
    begin
      tx_cv_q <= 1'b0;
      if (tx_acc)
        tx_in_pay_q <= tx_coded;
      unique case (tx_ph_q)
        dcfree_pkg::PH_FIRST:
          if (tx_acc)
          begin
            tx_chip_q <= tx_nrz;
            tx_cv_q <= 1'b1;
            tx_second_q <= ~tx_nrz;
            if (man_on && tx_coded)
              tx_ph_q <= dcfree_pkg::PH_SECOND;
          end
        dcfree_pkg::PH_SECOND:
          if (chip_tick)
          begin
            tx_chip_q <= tx_second_q;
            tx_cv_q <= 1'b1;
            tx_ph_q <= dcfree_pkg::PH_FIRST;
          end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive decoder; FIFO side sees NRZ only
  dcfree_pkg::chip_phase_e rx_ph_q;
  logic rx_first_q, rx_bit_q, rx_bv_q, rx_in_pay_q;
  logic rx_man, rx_pair, rx_raw, rx_out, rx_emit, rx_wh, rx_wh_bit;
  logic rx_seed, rx_bad;

  assign rx_man = man_on && rx_coded;
  assign rx_pair = rx_chip_valid && rx_man &&
                   (rx_ph_q == dcfree_pkg::PH_SECOND);
  assign rx_emit = rx_chip_valid && (!rx_man || rx_pair);
  assign rx_raw = rx_pair ? rx_first_q : rx_chip;
  assign rx_wh = wh_on && rx_coded;
  assign rx_out = rx_raw ^ (rx_wh && rx_wh_bit);
  assign rx_seed = rx_emit && rx_coded && !rx_in_pay_q;
  // A pair of equal chips is no valid symbol
  assign rx_bad = rx_pair && (rx_first_q == rx_chip);
  assign rx_bit = rx_bit_q;
  assign rx_bit_valid = rx_bv_q;

  whiten_lfsr #(.TAPS(WH_TAPS), .SEED(WH_SEED)) u_rx_lfsr (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .load(rx_seed),
    .step(rx_emit && rx_wh),
    .rnd(rx_wh_bit)
  );

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_ph_q <= dcfree_pkg::PH_FIRST;
      rx_first_q <= 1'b0;
      rx_bit_q <= 1'b0;
      rx_bv_q <= 1'b0;
      rx_in_pay_q <= 1'b0;
      code_err_q <= 1'b0;
    end
    else if (ce)
    begin
      rx_bv_q <= rx_emit;
      if (rx_emit)
      begin
        rx_bit_q <= rx_out;
        rx_in_pay_q <= rx_coded;
      end
      if (rx_chip_valid)
      begin
        rx_first_q <= rx_chip;
        rx_ph_q <= (rx_man && rx_ph_q == dcfree_pkg::PH_FIRST) ?
                   dcfree_pkg::PH_SECOND : dcfree_pkg::PH_FIRST;
      end
      // Set wins over a same-cycle clear
      code_err_q <= rx_bad || (code_err_q && !clr_err);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt routing and start condition
  logic thr_hit, start_ok, rx0_src, rx1_src, irq0_d, irq1_d;
  logic irq0_q, irq1_q, start_q, clr_q;
  logic [1:0] pre_q, tol_q, adr_q;
  logic [7:0] len_q;
  logic exact_q;

  assign thr_hit = {1'b0, fifo_count} >= thresh_q;
  assign start_ok = irqsel_q[`IRQ_TXSTART] ? ev_fifo_not_empty :
                    thr_hit;
  assign rx0_src = (irqsel_q[`IRQ_RX0] == `RX0_PAYLOAD) ? ev_payload_ready :
                   (irqsel_q[`IRQ_RX0] == `RX0_WRBYTE) ? ev_write_byte :
                   (irqsel_q[`IRQ_RX0] == `RX0_NEMPTY) ? ev_fifo_not_empty :
                   (irqsel_q[`IRQ_ADRS] != `ADRS_OFF) ? ev_adrs_match :
                   ev_sync;
  assign rx1_src = (irqsel_q[`IRQ_RX1] == `RX1_CRCOK) ? ev_crc_ok :
                   (irqsel_q[`IRQ_RX1] == `RX1_FULL) ? ev_fifo_full :
                   (irqsel_q[`IRQ_RX1] == `RX1_RSSI) ? ev_rssi :
                   thr_hit;
  assign irq0_d = is_rx ? rx0_src :
                  is_stby ? (irqsel_q[`IRQ_RX0] == `RX0_NEMPTY) &&
                            ev_fifo_not_empty :
                  is_tx ? (irqsel_q[`IRQ_TXSTART] ? ev_fifo_not_empty :
                           thr_hit) : 1'b0;
  assign irq1_d = is_rx ? rx1_src :
                  is_stby ? ((irqsel_q[`IRQ_RX1] == `RX1_FULL) &&
                             ev_fifo_full) ||
                            ((irqsel_q[`IRQ_RX1] == `RX1_THRESH) &&
                             thr_hit) :
                  is_tx ? (irqsel_q[`IRQ_TX1] ? ev_tx_done :
                           ev_fifo_full) : 1'b0;
  assign irq0 = irq0_q;
  assign irq1 = irq1_q;
  assign tx_start = start_q;
  assign fifo_clear = clr_q;
  assign preamble_bytes = pre_q;
  assign sync_tol = tol_q;
  assign len_limit = len_q;
  assign len_exact = exact_q;
  assign adrs_filt = adr_q;

  // Preamble, sync tolerance and address filter reach the framer only in the mode they apply to; the exact-length flag
  // in every mode, the length limit in every mode except transmit with variable length
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq0_q <= 1'b0;
      irq1_q <= 1'b0;
      start_q <= 1'b0;
      clr_q <= 1'b0;
      pre_q <= 2'h0;
      tol_q <= 2'h0;
      adr_q <= 2'h0;
      len_q <= 8'h00;
      exact_q <= 1'b0;
    end
    else if (ce)
    begin
      irq0_q <= irq0_d;
      irq1_q <= irq1_d;
      start_q <= is_tx && pkt_mode && start_ok;
      clr_q <= is_rx && ctrl_q[`CTRL_AUTOCLR] && ev_crc_fail;
      pre_q <= is_tx ? pktcfg_q[`PKT_PREAMBLE] : 2'h0;
      tol_q <= is_rx ? pktcfg_q[`PKT_SYNCTOL] : 2'h0;
      adr_q <= is_rx ? irqsel_q[`IRQ_ADRS] : 2'h0;
      exact_q <= !pktcfg_q[`PKT_VARLEN];
      len_q <= (is_tx && pktcfg_q[`PKT_VARLEN]) ? 8'h00 : paylen_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_tx_take;
    ce && tx_acc;
  endsequence
  sequence s_man_take;
    s_tx_take ##0 man_on && tx_coded;
  endsequence

  // Outside packet mode a coded bit must never open a chip pair
  property p_gate;
    s_tx_take ##0 !pkt_mode |=> tx_ph_q == dcfree_pkg::PH_FIRST;
  endproperty
  a_gate: assert property (p_gate) else $error("coding outside packet");

  property p_man_pair;
    s_man_take |=> tx_cv_q && tx_chip_q == $past(tx_nrz) &&
                   tx_second_q == !tx_chip_q;
  endproperty
  a_man_pair: assert property (p_man_pair) else $error("bad chip pair");

  property p_half_rate;
    s_man_take |=> !tx_bit_ready;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("rate not half");

  property p_nrz_head;
    s_tx_take ##0 !tx_coded |=> tx_chip_q == $past(tx_bit) &&
                                tx_ph_q == dcfree_pkg::PH_FIRST;
  endproperty
  a_nrz_head: assert property (p_nrz_head) else $error("header coded");

  property p_rx_nrz;
    ce && rx_pair && !rx_wh |=> rx_bv_q && rx_bit_q == $past(rx_first_q);
  endproperty
  a_rx_nrz: assert property (p_rx_nrz) else $error("decode wrong");

  property p_wh_tx;
    s_tx_take ##0 tx_wh && !man_on |=>
      tx_chip_q == ($past(tx_bit) ^ $past(tx_wh_bit));
  endproperty
  a_wh_tx: assert property (p_wh_tx) else $error("whitening wrong");

  property p_wh_rx;
    ce && rx_chip_valid && rx_wh && !man_on |=>
      rx_bit_q == ($past(rx_chip) ^ $past(rx_wh_bit));
  endproperty
  a_wh_rx: assert property (p_wh_rx) else $error("dewhitening wrong");

  property p_irq_sync;
    ce && is_rx && irqsel_q[`IRQ_RX0] == `RX0_SYNC |=>
      irq0 == $past(irqsel_q[`IRQ_ADRS] != `ADRS_OFF ?
                    ev_adrs_match : ev_sync);
  endproperty
  a_irq_sync: assert property (p_irq_sync) else $error("irq0 source");

  property p_stby;
    ce && is_stby && irqsel_q[`IRQ_RX1] == `RX1_CRCOK |=> !irq1;
  endproperty
  a_stby: assert property (p_stby) else $error("standby irq1 set");

  property p_tx_done;
    ce && is_tx && irqsel_q[`IRQ_TX1] |=> irq1 == $past(ev_tx_done);
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("irq1 not done");

  property p_start;
    ce && is_tx && pkt_mode && !irqsel_q[`IRQ_TXSTART] |=>
      tx_start == $past(thr_hit);
  endproperty
  a_start: assert property (p_start) else $error("start wrong");

  property p_clear;
    ce && ev_crc_fail && !is_rx |=> !fifo_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("clear outside rx");
endmodule // dcfree_coder

// ==== hw/dcfree_pkg.sv ====
// Types shared by the line coder
package dcfree_pkg;
  typedef logic [2:0] chip_mode_t;
  typedef enum logic {PH_FIRST, PH_SECOND} chip_phase_e;
endpackage

// ==== hw/dcfree_regs.svh ====
// Register map, field positions, codes and reset values of the coder
`ifndef DCFREE_REGS_SVH
`define DCFREE_REGS_SVH

// Register indices
`define REG_CTRL 4'h0
`define REG_IRQSEL 4'h1
`define REG_THRESH 4'h2
`define REG_PAYLEN 4'h3
`define REG_PKTCFG 4'h4
`define REG_RATE_LO 4'h5
`define REG_RATE_HI 4'h6
`define REG_STATUS 4'h7

// Control register fields
`define CTRL_MODE 7:5
`define CTRL_PKT_BIT 4
`define CTRL_DMODE 4:3
`define CTRL_MAN 2
`define CTRL_WH 1
`define CTRL_AUTOCLR 0

// Interrupt selection register fields
`define IRQ_RX0 7:6
`define IRQ_RX1 5:4
`define IRQ_TXSTART 3
`define IRQ_TX1 2
`define IRQ_ADRS 1:0

// Packet configuration register fields
`define PKT_VARLEN 7
`define PKT_PREAMBLE 6:5
`define PKT_SYNCTOL 1:0

// Status register bits
`define ST_IRQ0 0
`define ST_IRQ1 1
`define ST_TXSTART 2
`define ST_CODEERR 3

// Chip modes
`define MODE_STBY 3'h1
`define MODE_RX 3'h3
`define MODE_TX 3'h4

// Interrupt source selections
`define RX0_PAYLOAD 2'h0
`define RX0_WRBYTE 2'h1
`define RX0_NEMPTY 2'h2
`define RX0_SYNC 2'h3
`define RX1_CRCOK 2'h0
`define RX1_FULL 2'h1
`define RX1_RSSI 2'h2
`define RX1_THRESH 2'h3
`define ADRS_OFF 2'h0

// Reset values
`define CTRL_RST 8'h20
`define IRQSEL_RST 8'h00
`define THRESH_RST 8'h10
`define PAYLEN_RST 8'h40
`define PKTCFG_RST 8'h00
`define RATE_RST 16'h0007

// Whitening generator defaults
`define WH_TAPS 9'h021
`define WH_SEED 9'h1ff

`endif

// ==== hw/whiten_lfsr.sv ====
// Nine-bit pseudo-random generator for whitening
`timescale 1ns/10ps
`include "dcfree_regs.svh"
module whiten_lfsr #(
  parameter logic [8:0] TAPS = `WH_TAPS,
  parameter logic [8:0] SEED = `WH_SEED
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic load,
  input wire logic step,
  output logic rnd
);
  logic [8:0] state_q;
  logic [8:0] state_d;
  logic [8:0] base;

  ////////////////////////////////////////////////////////////////////////
  // Seed is usable in the very cycle it is loaded
  assign base = load ? SEED : state_q;
  assign rnd = base[0];
  assign state_d = {^(base & TAPS), base[8:1]};

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= SEED;
    else if (ce && step)
      state_q <= state_d;
    else if (ce && load)
      state_q <= SEED;
  end
endmodule // whiten_lfsr

// ==== tb/chip_peer.sv ====
// Far-end peer radio: records sent chips and plays them back
`timescale 1ns/10ps
module chip_peer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tx_chip,
  input wire logic tx_chip_valid,
  input wire logic tx_coded,
  input wire logic play,
  input wire logic [7:0] flip_at,
  output logic rx_chip,
  output logic rx_coded,
  output logic rx_chip_valid
);
  logic chip_q[$];
  logic coded_q[$];
  logic coded_d;
  int idx;
  //////////////////////////////////////////////////////////////////////////////
  // Coded flag lags one edge, so it matches the bit taken before the chip
  always @(posedge clk)
  begin
    coded_d <= tx_coded;
    if (tx_chip_valid)
    begin
      chip_q.push_back(tx_chip);
      coded_q.push_back(coded_d);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Same chips back except the one at index flip_at, which is inverted
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_chip <= 1'b0;
      rx_coded <= 1'b0;
      rx_chip_valid <= 1'b0;
      idx = 0;
    end
    else if (play && !rx_chip_valid && idx < chip_q.size())
    begin
      rx_chip <= chip_q[idx] ^ (idx == int'(flip_at));
      rx_coded <= coded_q[idx];
      rx_chip_valid <= 1'b1;
      idx = idx + 1;
    end
    else
    begin
      // Idle line toggles so a stale chip never passes for data
      rx_chip <= ~rx_chip;
      rx_chip_valid <= 1'b0;
      if (!play)
      begin
        idx = 0;
        rx_coded <= 1'b0;
      end
    end
  end
endmodule // chip_peer

// ==== tb/dcfree_coder_tb_top.sv ====
// Self-checking bench for the packet line coder
`timescale 1ns/10ps
`include "dcfree_regs.svh"
module dcfree_coder_tb_top;
  localparam logic [11:0] FRAME = 12'hbb2;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_bit = 1'b0;
  logic tx_coded = 1'b0;
  logic tx_bit_valid = 1'b0;
  logic [6:0] fifo_count = 7'h00;
  logic [9:0] ev = 10'h000;
  logic play = 1'b0;
  logic [7:0] flip_at = 8'hff;
  logic [7:0] reg_rdata, len_limit;
  logic tx_bit_ready, tx_chip, tx_chip_valid, rx_chip, rx_coded;
  logic rx_chip_valid, rx_bit, rx_bit_valid, irq0, irq1, tx_start;
  logic fifo_clear, len_exact;
  logic [1:0] preamble_bytes, sync_tol, adrs_filt;
  logic chips[$];
  logic bits_seen[$];
  int stamps[$];
  int cyc = 0;
  int n_mismatch = 0;
  int n_tests = 0;
  always #2.5 clk = ~clk;
  dcfree_coder DUT (
    .clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_bit(tx_bit), .tx_coded(tx_coded),
    .tx_bit_valid(tx_bit_valid), .tx_bit_ready(tx_bit_ready),
    .tx_chip(tx_chip), .tx_chip_valid(tx_chip_valid), .rx_chip(rx_chip),
    .rx_coded(rx_coded), .rx_chip_valid(rx_chip_valid), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .fifo_count(fifo_count),
    .ev_payload_ready(ev[0]), .ev_write_byte(ev[1]),
    .ev_fifo_not_empty(ev[2]), .ev_sync(ev[3]), .ev_adrs_match(ev[4]),
    .ev_crc_ok(ev[5]), .ev_crc_fail(ev[6]), .ev_fifo_full(ev[7]),
    .ev_rssi(ev[8]), .ev_tx_done(ev[9]), .irq0(irq0), .irq1(irq1),
    .tx_start(tx_start), .fifo_clear(fifo_clear),
    .preamble_bytes(preamble_bytes), .sync_tol(sync_tol),
    .len_limit(len_limit), .len_exact(len_exact), .adrs_filt(adrs_filt));
  chip_peer peer (
    .clk(clk), .nrst(nrst), .tx_chip(tx_chip),
    .tx_chip_valid(tx_chip_valid), .tx_coded(tx_coded), .play(play),
    .flip_at(flip_at), .rx_chip(rx_chip), .rx_coded(rx_coded),
    .rx_chip_valid(rx_chip_valid));
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (tx_chip_valid)
    begin
      chips.push_back(tx_chip);
      stamps.push_back(cyc);
    end
    if (rx_bit_valid)
      bits_seen.push_back(rx_bit);
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [19:0] seen,
    input logic [19:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [19:0] pack(input logic q[$]);
    logic [19:0] v;
    v = 20'h00000;
    foreach (q[i])
      v = {v[18:0], q[i]};
    return v;
  endfunction
  // Reference whitening of one payload byte, freshly seeded
  function automatic logic [7:0] ref_white(input logic [7:0] d);
    logic [8:0] s;
    logic [7:0] w;
    s = `WH_SEED;
    for (int i = 7; i >= 0; i--)
    begin
      w[i] = d[i] ^ s[0];
      s = {^(s & `WH_TAPS), s[8:1]};
    end
    return w;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", reg_rdata, exp);
  endtask
  // Upper four bits go out plain, lower eight as payload
  task automatic send(input logic [7:0] ctrl);
    int n;
    logic t;
    wr(`REG_CTRL, ctrl);
    chips.delete();
    stamps.delete();
    peer.chip_q.delete();
    peer.coded_q.delete();
    for (int i = 11; i >= 0; i--)
    begin
      @(posedge clk);
      tx_bit <= FRAME[i];
      tx_coded <= (i < 8);
      tx_bit_valid <= 1'b1;
      n = 0;
      t = 1'b0;
      while (!t && n < 40)
      begin
        @(negedge clk);
        t = tx_bit_ready;
        n++;
      end
      check("tx_bit_ready", t, 20'h00001);
    end
    @(posedge clk);
    tx_bit_valid <= 1'b0;
    repeat (60) @(posedge clk);
  endtask
  task automatic replay(input logic [7:0] ctrl);
    wr(`REG_CTRL, ctrl);
    bits_seen.delete();
    @(posedge clk);
    play <= 1'b1;
    repeat (60) @(posedge clk);
    play <= 1'b0;
    @(posedge clk);
  endtask
  task automatic irq_case(input logic [7:0] ctrl, input logic [7:0] sel,
    input logic [9:0] e, input logic [6:0] cnt, input logic [2:0] exp);
    wr(`REG_CTRL, ctrl);
    wr(`REG_IRQSEL, sel);
    ev <= e;
    fifo_count <= cnt;
    repeat (2) @(posedge clk);
    #1 check("start and irq lines", {tx_start, irq1, irq0}, exp);
  endtask
  task automatic pulse_fail(input logic exp);
    @(posedge clk);
    ev[6] <= 1'b1;
    @(posedge clk);
    ev[6] <= 1'b0;
    #1 check("fifo_clear", fifo_clear, exp);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(`REG_CTRL, `CTRL_RST);
    rd_chk(`REG_IRQSEL, `IRQSEL_RST);
    rd_chk(`REG_THRESH, `THRESH_RST);
    rd_chk(`REG_PAYLEN, `PAYLEN_RST);
    rd_chk(`REG_PKTCFG, `PKTCFG_RST);
    rd_chk(`REG_RATE_LO, 8'h07);
    rd_chk(`REG_RATE_HI, 8'h00);
    // Write with the clock enable low must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(`REG_THRESH, 8'h33);
    ce <= 1'b1;
    rd_chk(`REG_THRESH, `THRESH_RST);
    wr(4'h9, 8'h5a);
    rd_chk(4'h9, 8'h00);
  endtask
  // Chip every third cycle, faster than reset, so spacing between chips is visible
  task automatic t_manchester();
    wr(`REG_RATE_LO, 8'h02);
    send(8'h94);
    check("chip count", chips.size(), 20'h00014);
    check("manchester chips", pack(chips), 20'hb9a59);
    for (int i = 1; i < stamps.size(); i++)
      check("chip spacing", stamps[i] - stamps[i-1], 20'h00003);
    flip_at <= 8'h04;
    replay(8'h74);
    check("decoded bits", pack(bits_seen), 20'h00b32);
    rd_chk(`REG_STATUS, 8'h08);
    wr(`REG_STATUS, 8'h08);
    rd_chk(`REG_STATUS, 8'h00);
    flip_at <= 8'hff;
    send(8'h84);
    check("continuous mode chips", pack(chips), 20'h00bb2);
    replay(8'h64);
    check("continuous mode bits", pack(bits_seen), 20'h00bb2);
  endtask
  task automatic t_whiten();
    logic [19:0] got;
    send(8'h92);
    got = pack(chips);
    check("whitened count", chips.size(), 20'h0000c);
    check("plain head", got[11:8], 20'h0000b);
    check("payload scrambled", got[7:0] !== 8'hb2, 20'h00001);
    check("whitened payload", got[7:0], ref_white(FRAME[7:0]));
    replay(8'h72);
    check("dewhitened bits", pack(bits_seen), 20'h00bb2);
  endtask
  task automatic t_irq();
    irq_case(8'h70, 8'h00, 10'h001, 7'h00, 3'h1);
    irq_case(8'h70, 8'h00, 10'h020, 7'h00, 3'h2);
    irq_case(8'h70, 8'h00, 10'h3de, 7'h7f, 3'h0);
    irq_case(8'h70, 8'h50, 10'h082, 7'h00, 3'h3);
    rd_chk(`REG_STATUS, 8'h03);
    irq_case(8'h70, 8'h50, 10'h37d, 7'h7f, 3'h0);
    irq_case(8'h70, 8'ha0, 10'h104, 7'h00, 3'h3);
    irq_case(8'h70, 8'ha0, 10'h2fb, 7'h7f, 3'h0);
    irq_case(8'h70, 8'hf0, 10'h008, 7'h10, 3'h3);
    irq_case(8'h70, 8'hf0, 10'h010, 7'h0f, 3'h0);
    irq_case(8'h70, 8'hf1, 10'h010, 7'h00, 3'h1);
    irq_case(8'h70, 8'hf1, 10'h008, 7'h00, 3'h0);
    irq_case(8'h30, 8'ha0, 10'h3ff, 7'h00, 3'h1);
    irq_case(8'h30, 8'h50, 10'h3ff, 7'h7f, 3'h2);
    irq_case(8'h30, 8'h30, 10'h3ff, 7'h10, 3'h2);
    irq_case(8'h30, 8'h30, 10'h37f, 7'h0f, 3'h0);
    irq_case(8'h30, 8'h00, 10'h3ff, 7'h7f, 3'h0);
    irq_case(8'h90, 8'h00, 10'h000, 7'h10, 3'h5);
    irq_case(8'h90, 8'h00, 10'h080, 7'h0f, 3'h2);
    irq_case(8'h90, 8'h0c, 10'h004, 7'h00, 3'h5);
    irq_case(8'h90, 8'h0c, 10'h200, 7'h00, 3'h2);
    irq_case(8'h90, 8'h0c, 10'h1fb, 7'h7f, 3'h0);
    irq_case(8'h10, 8'ha0, 10'h3ff, 7'h7f, 3'h0);
    ev <= 10'h000;
    fifo_count <= 7'h00;
  endtask
  task automatic t_opts();
    wr(`REG_PKTCFG, 8'he3);
    wr(`REG_PAYLEN, 8'h2a);
    wr(`REG_IRQSEL, 8'h02);
    wr(`REG_CTRL, 8'h90);
    @(posedge clk);
    #1 check("tx options", {preamble_bytes, sync_tol, adrs_filt, len_exact,
      len_limit}, 20'h06000);
    wr(`REG_CTRL, 8'h71);
    @(posedge clk);
    #1 check("rx options", {preamble_bytes, sync_tol, adrs_filt, len_exact,
      len_limit}, 20'h01c2a);
    pulse_fail(1'b1);
    wr(`REG_CTRL, 8'h70);
    pulse_fail(1'b0);
    wr(`REG_PKTCFG, 8'h00);
    wr(`REG_CTRL, 8'h91);
    @(posedge clk);
    #1 check("fixed length", {len_exact, len_limit}, 20'h0012a);
    pulse_fail(1'b0);
  endtask
  // Host send then receive, watching the lines as the host would
  task automatic t_host();
    wr(`REG_IRQSEL, 8'h8c);
    wr(`REG_CTRL, 8'h30);
    ev <= 10'h004;
    repeat (2) @(posedge clk);
    #1 check("standby fill", {tx_start, irq1, irq0}, 20'h1);
    wr(`REG_CTRL, 8'h90);
    @(posedge clk);
    #1 check("tx entry", {tx_start, irq1, irq0}, 20'h5);
    @(posedge clk);
    ev <= 10'h204;
    repeat (2) @(posedge clk);
    #1 check("tx done", {tx_start, irq1, irq0}, 20'h7);
    // One more bit period before leaving transmit
    repeat (3) @(posedge clk);
    wr(`REG_CTRL, 8'h30);
    wr(`REG_CTRL, 8'h70);
    ev <= 10'h000;
    // Receiver start-up allowance before anything is expected
    repeat (8) @(posedge clk);
    ev <= 10'h024;
    repeat (2) @(posedge clk);
    #1 check("rx crc ok", {tx_start, irq1, irq0}, 20'h3);
    wr(`REG_CTRL, 8'h30);
    @(posedge clk);
    #1 check("stby drain", {tx_start, irq1, irq0}, 20'h1);
    @(posedge clk);
    ev <= 10'h000;
    repeat (2) @(posedge clk);
    #1 check("fifo drained", {tx_start, irq1, irq0}, 20'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_manchester();
    t_whiten();
    t_irq();
    t_opts();
    t_host();
    give_verdict();
  end
  // Whole run needs under a thousand cycles; this only cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule // dcfree_coder_tb_top
